/* design/bss_boot_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module bss_boot_decode (
  input wire logic [1:0] pin_status_in,
  input wire bss_pkg::bss_lc_t lifecycle_in,
  input wire logic [3:0] flash_sel_in,
  output bss_pkg::bss_src_t source_out,
  output logic valid_out
);
  import bss_pkg::*;

  always_comb begin
    source_out = BSS_SRC_SNOR;
    valid_out = 1'b1;
    if (pin_status_in[1] && lifecycle_in == BSS_LC_OPEN) begin // [R15] [R12]
      source_out = BSS_SRC_DEV;
    end else if (pin_status_in[0]) begin // [R15]
      source_out = BSS_SRC_SERIAL;
    end else begin
      case (flash_sel_in) // [R16]
        FSEL_DEFAULT: source_out = BSS_SRC_SNOR;
        FSEL_SD1: source_out = BSS_SRC_SD1;
        FSEL_EMMC1: source_out = BSS_SRC_EMMC1;
        FSEL_SNOR: source_out = BSS_SRC_SNOR;
        FSEL_HYPER: source_out = BSS_SRC_HYPER;
        FSEL_SD2: source_out = BSS_SRC_SD2;
        FSEL_EMMC2: source_out = BSS_SRC_EMMC2;
        // Unlisted codes are an invalid scenario
        default: valid_out = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* design/bss_pkg.sv */
package bss_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int WDG_RELOAD_NS = 1000;
  localparam int WDG_RELOAD_CYC = WDG_RELOAD_NS / CLK_PERIOD_NS;
  localparam int WDG_CNT_W = 8;

  // ----------------------------------------
  // Fuse field positions and codes
  // ----------------------------------------
  localparam int WDG_EN_BIT = 0;
  localparam int TEST_KILL_BIT = 20;
  localparam int BOOT_TAMP_BIT = 1;
  localparam int TAMP_W = 19;
  localparam int EXT_TAMP_W = 8;
  localparam int TAMP_SKIP_BIT = 17;
  localparam int FIELD_W = 4;
  localparam int REMAP_PORT_LSB = 21;
  localparam int REMAP_PIN_LSB = 25;
  localparam int FLASH_SEL_LSB = 5;
  localparam logic [31:0] LC_UNPROV_CODE = 32'h0000000F;
  localparam logic [31:0] LC_PROV_CODE = 32'h000001EF;
  localparam logic [3:0] FSEL_DEFAULT = 4'h0;
  localparam logic [3:0] FSEL_SD1 = 4'h1;
  localparam logic [3:0] FSEL_EMMC1 = 4'h2;
  localparam logic [3:0] FSEL_SNOR = 4'h3;
  localparam logic [3:0] FSEL_HYPER = 4'h5;
  localparam logic [3:0] FSEL_SD2 = 4'h7;
  localparam logic [3:0] FSEL_EMMC2 = 4'h8;
  // Default secondary pin location when the remap field is blank (arbitrary)
  localparam logic [3:0] SEC_PIN_PORT_DEF = 4'h0;
  localparam logic [3:0] SEC_PIN_INDEX_DEF = 4'h6;

  // ----------------------------------------
  // Vector table, attribution, firewall
  // ----------------------------------------
  localparam logic [1:0] VEC_SP_IDX = 2'h0;
  localparam logic [1:0] VEC_RESET_IDX = 2'h1;
  localparam int GRAN_LOG2 = 5;
  localparam int ATU_REGIONS = 8;
  localparam logic [31:0] ATU_BASE [ATU_REGIONS] = '{32'h08010000, 32'h18007C00,
    32'h20000000, 32'h24104000, 32'h30000000, 32'h34106000, 32'h40000000, 32'h60000000};
  localparam logic [31:0] ATU_LIMIT [ATU_REGIONS] = '{32'h0801FFFF, 32'h18007FFF,
    32'h24101FFF, 32'h2FFFFFFF, 32'h340FFFFF, 32'h3FFFFFFF, 32'h4FFFFFFF, 32'hFFFFFFFF};
  // Set bit: region is plain nonsecure; clear: secure, nonsecure-callable
  localparam logic [ATU_REGIONS-1:0] ATU_NS_MASK = 8'hCD;
  localparam int FW_REGIONS = 7;
  localparam logic [FW_REGIONS-1:0] FW_CLEAR = 7'h00;
  localparam logic [FW_REGIONS-1:0] FW_LOAD_MASK = 7'h00;
  localparam logic [FW_REGIONS-1:0] FW_AUTH_MASK = 7'h01;
  localparam logic [FW_REGIONS-1:0] FW_SEC_ONLY = 7'h7F;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    BSS_SRC_DEV, BSS_SRC_SERIAL, BSS_SRC_SD1, BSS_SRC_SD2,
    BSS_SRC_EMMC1, BSS_SRC_EMMC2, BSS_SRC_SNOR, BSS_SRC_HYPER
  } bss_src_t;

  typedef enum logic [1:0] {
    BSS_LC_OPEN, BSS_LC_UNPROV, BSS_LC_PROV, BSS_LC_INVALID
  } bss_lc_t;

  typedef struct packed {
    logic pin_reset_flag;
    logic power_on_reset_flag;
    logic brownout_reset_flag;
    logic software_reset_flag;
    logic window_watchdog_reset_flag;
    logic independent_watchdog_reset_flag;
    logic low_power_security_reset_flag;
  } bss_cause_t;

  typedef struct packed {
    logic lifecycle_unlocked_cfg;
    logic [31:0] security_control_fuse_word;
    logic [31:0] secure_boot_fuse_word;
    logic [31:0] boot_tamper_enable_fuse_word;
    logic [31:0] tamper_enable_fuse_word;
    logic [31:0] tamper_kind_fuse_word;
    logic [31:0] tamper_level_fuse_word;
    logic [31:0] boot_pin_remap_fuse;
    logic [31:0] flash_boot_select_fuse;
  } bss_fuse_t;

  typedef struct packed {
    logic [TAMP_W-1:0] enable;
    logic [TAMP_W-1:0] confirmed;
    logic [EXT_TAMP_W-1:0] active_high;
  } bss_tamper_cfg_t;

  typedef struct packed {
    logic atu_enable;
    logic mpu_keep;
    logic [FW_REGIONS-1:0] fw_secure_only;
    logic instruction_cache_enable;
    logic data_cache_enable;
  } bss_secpol_t;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic bss_lc_t lc_of(input bss_fuse_t f);
    lc_of = BSS_LC_INVALID;
    if (f.lifecycle_unlocked_cfg) begin
      lc_of = BSS_LC_OPEN;
      if (f.security_control_fuse_word[TEST_KILL_BIT]) begin
        if (f.secure_boot_fuse_word == LC_UNPROV_CODE) begin
          lc_of = BSS_LC_UNPROV;
        end else if (f.secure_boot_fuse_word == LC_PROV_CODE) begin
          lc_of = BSS_LC_PROV;
        end
      end
    end
  endfunction

  function automatic logic aligned(input logic [31:0] a);
    aligned = (a[GRAN_LOG2-1:0] == '0);
  endfunction

  function automatic logic atu_secure(input logic [31:0] a);
    atu_secure = 1'b1;
    for (int i = 0; i < ATU_REGIONS; i++) begin
      if (a[31:GRAN_LOG2] >= ATU_BASE[i][31:GRAN_LOG2] &&
          a[31:GRAN_LOG2] <= ATU_LIMIT[i][31:GRAN_LOG2] && ATU_NS_MASK[i]) begin
        atu_secure = 1'b0;
      end
    end
  endfunction

endpackage

/* design/bss_top.sv */
// What this block does
// R1: Fetch stack pointer from entry zero, then reset vector; missing handler means failure.
// R2: Latch reset cause, request its clearing, only then evaluate cause bits.
// R3: Exactly one of seven cause flags set classifies as system reset.
// R4: Watchdog-enable fuse bit set: keep reloading the independent watchdog.
// R5: Potential tamper unblocks crypto at start; withdrawn at handover or failure.
// R6: Confirmed tamper: stop forever, load no image.
// R7: Boot tamper enable bit gates tamper enables; internal tamper ten skipped.
// R8: Kind word picks confirmed/potential; level word gives external active level.
// R9: Unlocked config, test-kill bit, secure-boot word 0xF: locked unprovisioned.
// R10: Same with secure-boot word 0x1EF: locked provisioned.
// R11: Boot source codes zero to seven as listed.
// R12: Development boot only when development-open; reopen debug, loop forever.
// R13: Boot pins captured into two-bit status, bit 0 primary, bit 1 secondary.
// R14: Remap fuse fields give secondary pin port and pin identifiers.
// R15: Secondary pin checked first; clear or not permitted falls back to primary.
// R16: Both pins clear: flash-select fuse field mapped to boot config.
// R17: Dev boot clears attribution, protection, firewall, caches; loader keeps instruction_cache.
// R18: Failure keeps attribution, firewall secure-only, caches off.
// R19: Eight attribution regions, 32-byte grain, default secure, stricter wins.
// R20: Execution only inside 32-byte aligned authenticated loader region.
// R21: Seven firewall regions whose access changes with boot phase.
// R22: Instruction_cache on early, data_cache during secure boot, cleaned at its end.
// R23: Life-cycle settled before the boot source is decoded.
`timescale 1ns/100ps
`default_nettype none
module bss_top (
  input wire logic clk_in,
  input wire logic reset_in,
  output logic vec_req_out,
  output logic [1:0] vec_index_out,
  input wire logic [31:0] vec_data_in,
  input wire logic vec_valid_in,
  input wire logic exc_in,
  input wire logic exc_handler_ok_in,
  input wire bss_pkg::bss_cause_t hw_reset_cause_reg_in,
  output logic cause_clear_out,
  output logic system_reset_out,
  input wire logic [1:0] boot_pins_in,
  input wire bss_pkg::bss_fuse_t fuse_in,
  input wire logic potential_tamper_in,
  input wire logic confirmed_tamper_in,
  input wire logic [31:0] loader_start_in,
  input wire logic [31:0] loader_end_in,
  input wire logic image_ready_in,
  input wire logic image_ok_in,
  input wire logic [31:0] query_addr_in,
  input wire logic fixed_secure_in,
  output logic [31:0] main_stack_pointer_out,
  output logic [31:0] reset_entry_vector_out,
  output logic wdg_reload_out,
  output logic crypto_unblock_out,
  output bss_pkg::bss_tamper_cfg_t tamper_cfg_out,
  output bss_pkg::bss_lc_t lifecycle_out,
  output logic [1:0] boot_pin_status_out,
  output logic [3:0] sec_pin_port_out,
  output logic [3:0] sec_pin_index_out,
  output bss_pkg::bss_src_t boot_source_out,
  output bss_pkg::bss_secpol_t secpol_out,
  output logic data_cache_clean_out,
  output logic debug_reopen_out,
  output logic handover_out,
  output logic fail_out,
  output logic query_secure_out,
  output logic query_exec_out
);
  import bss_pkg::*;

  localparam int WDG_BOUND = WDG_RELOAD_CYC + 1;

  typedef enum logic [3:0] {
    S_FETCH_SP, S_FETCH_VEC, S_CAUSE_READ, S_CAUSE_CLEAR, S_CAUSE_EVAL,
    S_LIFECYCLE, S_TAMPER, S_DECODE, S_LOAD, S_HANDOVER,
    S_DEV_LOOP, S_TAMPER_LOOP, S_FAIL
  } bss_state_t;

  bss_state_t state_q;
  bss_cause_t cause_q;
  bss_src_t dec_src;
  logic dec_valid;
  logic [1:0] pin_meta_q, pin_sync_q;
  logic [WDG_CNT_W-1:0] wdg_cnt_q;
  logic [31:0] exec_base_q, exec_end_q;
  logic exec_set_q;
  logic exc_fatal, terminal, secure_boot, image_good;

  assign terminal = (state_q == S_FAIL) || (state_q == S_TAMPER_LOOP);
  assign exc_fatal = exc_in && !exc_handler_ok_in && !terminal;
  assign secure_boot = (lifecycle_out == BSS_LC_UNPROV) || (lifecycle_out == BSS_LC_PROV);
  assign image_good = image_ok_in && aligned(loader_start_in) && aligned(loader_end_in);

  bss_boot_decode u_decode (
    .pin_status_in(boot_pin_status_out),
    .lifecycle_in(lifecycle_out),
    .flash_sel_in(fuse_in.flash_boot_select_fuse[FLASH_SEL_LSB +: FIELD_W]),
    .source_out(dec_src),
    .valid_out(dec_valid)
  );

  // ----------------------------------------
  // Boot pin synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end else begin
      pin_meta_q <= boot_pins_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= S_FETCH_SP;
    end else if (exc_fatal) begin
      state_q <= S_FAIL; // [R1]
    end else begin
      case (state_q)
        S_FETCH_SP: if (vec_valid_in) state_q <= S_FETCH_VEC; // [R1]
        S_FETCH_VEC: begin
          if (vec_valid_in) begin
            // A blank reset entry counts as an undefined handler
            state_q <= (vec_data_in == '0) ? S_FAIL : S_CAUSE_READ; // [R1]
          end
        end
        S_CAUSE_READ: state_q <= S_CAUSE_CLEAR; // [R2]
        S_CAUSE_CLEAR: state_q <= S_CAUSE_EVAL; // [R2]
        S_CAUSE_EVAL: state_q <= S_LIFECYCLE;
        S_LIFECYCLE: state_q <= S_TAMPER; // [R23]
        S_TAMPER: state_q <= confirmed_tamper_in ? S_TAMPER_LOOP : S_DECODE; // [R6]
        S_DECODE: begin
          if (!dec_valid || lifecycle_out == BSS_LC_INVALID) begin
            state_q <= S_FAIL;
          end else if (dec_src == BSS_SRC_DEV) begin
            state_q <= S_DEV_LOOP; // [R12]
          end else begin
            state_q <= S_LOAD;
          end
        end
        S_LOAD: if (image_ready_in) state_q <= image_good ? S_HANDOVER : S_FAIL; // [R20]
        default: state_q <= state_q;
      endcase
    end
  end

  // ----------------------------------------
  // Vector fetch
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      vec_req_out <= 1'b0;
      vec_index_out <= VEC_SP_IDX;
      main_stack_pointer_out <= '0;
      reset_entry_vector_out <= '0;
    end else begin
      vec_req_out <= !vec_valid_in && !exc_fatal &&
                     (state_q == S_FETCH_SP || state_q == S_FETCH_VEC);
      vec_index_out <= (state_q == S_FETCH_SP && !vec_valid_in) ? VEC_SP_IDX : VEC_RESET_IDX;
      if (vec_valid_in && state_q == S_FETCH_SP) main_stack_pointer_out <= vec_data_in; // [R1]
      if (vec_valid_in && state_q == S_FETCH_VEC) reset_entry_vector_out <= vec_data_in; // [R1]
    end
  end

  // ----------------------------------------
  // Reset cause, pins, life cycle
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cause_q <= '0;
      cause_clear_out <= 1'b0;
      system_reset_out <= 1'b0;
      boot_pin_status_out <= 2'h0;
      lifecycle_out <= BSS_LC_INVALID;
    end else begin
      cause_clear_out <= (state_q == S_CAUSE_CLEAR); // [R2]
      if (state_q == S_CAUSE_READ) begin
        cause_q <= hw_reset_cause_reg_in; // [R2]
        boot_pin_status_out <= pin_sync_q; // [R13]
      end
      if (state_q == S_CAUSE_EVAL) system_reset_out <= $onehot(cause_q); // [R3]
      if (state_q == S_LIFECYCLE) lifecycle_out <= lc_of(fuse_in); // [R9] [R10] [R23]
    end
  end

  // ----------------------------------------
  // Watchdog and tamper handling
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wdg_cnt_q <= '0;
      wdg_reload_out <= 1'b0;
    end else begin
      // Loops still reload: a silent watchdog would restart a halted device
      wdg_reload_out <= 1'b0;
      if (fuse_in.security_control_fuse_word[WDG_EN_BIT] && state_q != S_HANDOVER) begin
        if (wdg_cnt_q == WDG_CNT_W'(WDG_RELOAD_CYC - 1)) begin
          wdg_cnt_q <= '0;
          wdg_reload_out <= 1'b1; // [R4]
        end else begin
          wdg_cnt_q <= wdg_cnt_q + 1'b1;
        end
      end else begin
        wdg_cnt_q <= '0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      crypto_unblock_out <= 1'b0;
      tamper_cfg_out <= '0;
    end else begin
      if (state_q == S_TAMPER && potential_tamper_in && !confirmed_tamper_in) begin
        crypto_unblock_out <= 1'b1; // [R5]
      end
      if (state_q == S_HANDOVER || state_q == S_FAIL || exc_fatal) begin
        crypto_unblock_out <= 1'b0; // [R5]
      end
      if (state_q == S_TAMPER && fuse_in.boot_tamper_enable_fuse_word[BOOT_TAMP_BIT]) begin
        tamper_cfg_out.enable <= fuse_in.tamper_enable_fuse_word[TAMP_W-1:0] &
                                 ~(TAMP_W'(1) << TAMP_SKIP_BIT); // [R7]
        tamper_cfg_out.confirmed <= fuse_in.tamper_kind_fuse_word[TAMP_W-1:0]; // [R8]
        tamper_cfg_out.active_high <= fuse_in.tamper_level_fuse_word[EXT_TAMP_W-1:0]; // [R8]
      end
    end
  end

  // ----------------------------------------
  // Boot source and scenario outputs
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      boot_source_out <= BSS_SRC_DEV;
      sec_pin_port_out <= SEC_PIN_PORT_DEF;
      sec_pin_index_out <= SEC_PIN_INDEX_DEF;
      debug_reopen_out <= 1'b0;
      handover_out <= 1'b0;
      fail_out <= 1'b0;
    end else begin
      if (fuse_in.boot_pin_remap_fuse[REMAP_PORT_LSB +: 2 * FIELD_W] != '0) begin
        sec_pin_port_out <= fuse_in.boot_pin_remap_fuse[REMAP_PORT_LSB +: FIELD_W]; // [R14]
        sec_pin_index_out <= fuse_in.boot_pin_remap_fuse[REMAP_PIN_LSB +: FIELD_W]; // [R14]
      end
      if (state_q == S_DECODE && dec_valid) boot_source_out <= dec_src; // [R11]
      debug_reopen_out <= (state_q == S_DEV_LOOP); // [R12]
      handover_out <= (state_q == S_HANDOVER);
      fail_out <= (state_q == S_FAIL);
    end
  end

  // ----------------------------------------
  // Security policy and caches
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      secpol_out <= '{atu_enable: 1'b1, mpu_keep: 1'b1, fw_secure_only: FW_LOAD_MASK,
                      instruction_cache_enable: 1'b0, data_cache_enable: 1'b0};
      data_cache_clean_out <= 1'b0;
    end else begin
      data_cache_clean_out <= 1'b0;
      if (state_q == S_FAIL) begin
        secpol_out.fw_secure_only <= FW_SEC_ONLY; // [R18]
        secpol_out.instruction_cache_enable <= 1'b0; // [R18]
        if (secure_boot) secpol_out.data_cache_enable <= 1'b0; // [R18]
      end else if (state_q == S_LIFECYCLE) begin
        secpol_out.instruction_cache_enable <= 1'b1; // [R22]
      end else if (state_q == S_DEV_LOOP) begin
        secpol_out <= '{atu_enable: 1'b0, mpu_keep: 1'b0, fw_secure_only: FW_CLEAR,
                        instruction_cache_enable: 1'b0, data_cache_enable: 1'b0}; // [R17]
      end else if (state_q == S_DECODE && dec_valid && dec_src != BSS_SRC_DEV) begin
        secpol_out.data_cache_enable <= secure_boot; // [R22]
        secpol_out.fw_secure_only <= secure_boot ? FW_AUTH_MASK : FW_LOAD_MASK; // [R21]
      end else if (state_q == S_LOAD && image_ready_in && image_good) begin
        secpol_out <= '{atu_enable: 1'b0, mpu_keep: 1'b0, fw_secure_only: FW_CLEAR,
                        instruction_cache_enable: 1'b1, data_cache_enable: 1'b0}; // [R17] [R21]
        data_cache_clean_out <= secpol_out.data_cache_enable; // [R22]
      end
    end
  end

  // ----------------------------------------
  // Attribution and execution lookup
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      exec_set_q <= 1'b0;
      exec_base_q <= '0;
      exec_end_q <= '0;
      query_secure_out <= 1'b1;
      query_exec_out <= 1'b0;
    end else begin
      if (state_q == S_LOAD && image_ready_in && image_good) begin
        exec_set_q <= 1'b1; // [R20]
        exec_base_q <= loader_start_in;
        exec_end_q <= loader_end_in;
      end
      // Either unit marking secure makes the address secure
      query_secure_out <= fixed_secure_in ||
                          (secpol_out.atu_enable && atu_secure(query_addr_in)); // [R19]
      query_exec_out <= exec_set_q && query_addr_in >= exec_base_q &&
                        query_addr_in < exec_end_q; // [R20]
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  cause_clear_a: assert property (state_q == S_CAUSE_READ |=> ##1 cause_clear_out ##1
    !cause_clear_out) else $error("cause clear not one pulse after read"); // [R2]
  sys_reset_a: assert property (state_q == S_CAUSE_EVAL && !exc_fatal |=>
    system_reset_out == $onehot(cause_q)) else $error("reset class wrong"); // [R3]
  wdg_reload_a: assert property (fuse_in.security_control_fuse_word[WDG_EN_BIT] &&
    state_q != S_HANDOVER |-> ##[0:WDG_BOUND] wdg_reload_out)
    else $error("watchdog not reloaded in time"); // [R4]
  crypto_drop_a: assert property (state_q == S_FAIL || state_q == S_HANDOVER |=>
    !crypto_unblock_out) else $error("crypto still unblocked"); // [R5]
  tamper_loop_a: assert property (state_q == S_TAMPER && confirmed_tamper_in && !exc_fatal |=>
    (state_q == S_TAMPER_LOOP) [*4]) else $error("confirmed tamper not held"); // [R6]
  tamper_skip_a: assert property (!tamper_cfg_out.enable[TAMP_SKIP_BIT])
    else $error("internal tamper ten enabled"); // [R7]
  lc_order_a: assert property (state_q == S_DECODE |-> lifecycle_out == lc_of(fuse_in) &&
    $past(state_q, 2) == S_LIFECYCLE) else $error("life cycle not settled"); // [R23]
  dev_only_a: assert property (state_q == S_DEV_LOOP |-> lifecycle_out == BSS_LC_OPEN &&
    boot_source_out == BSS_SRC_DEV) else $error("dev boot outside open state"); // [R12]
  fail_policy_a: assert property (state_q == S_FAIL |=> secpol_out.fw_secure_only ==
    FW_SEC_ONLY && !secpol_out.instruction_cache_enable) else $error("failure policy wrong"); // [R18]
  exec_region_a: assert property (query_exec_out |-> $past(query_addr_in) >= exec_base_q)
    else $error("execution outside loader"); // [R20]

  dev_c: cover property (state_q == S_DEV_LOOP);
  handover_c: cover property (state_q == S_HANDOVER && secpol_out.instruction_cache_enable);
  fail_c: cover property (state_q == S_FAIL);
  tamper_c: cover property (state_q == S_TAMPER_LOOP);

endmodule
`default_nettype wire

/* dv/bss_vec_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Vector table memory seen by the boot logic
// ----------------------------------------
module bss_vec_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic vec_req_in,
  input wire logic [1:0] vec_index_in,
  input wire logic [31:0] sp_word_in,
  input wire logic [31:0] vector_in,
  output logic [31:0] vec_data_out,
  output logic vec_valid_out
);
  logic [1:0] wait_q = 2'h0;
  initial vec_data_out = 32'hA5A5A5A5;
  initial vec_valid_out = 1'b0;
  // Data toggles outside the valid cycle so a stale word is never mistaken for a fetch
  always @(posedge clk_in) begin
    vec_valid_out <= 1'b0;
    vec_data_out <= ~vec_data_out;
    if (vec_req_in && !vec_valid_out) begin
      wait_q <= wait_q + 2'h1;
      if (!slow_in || wait_q == 2'h3) begin
        vec_valid_out <= 1'b1;
        vec_data_out <= (vec_index_in == 2'h0) ? sp_word_in : vector_in;
        wait_q <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/tb_boot_scenario_selector.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_boot_scenario_selector;
  import bss_pkg::*;
  logic clk_in = 1'b0, reset_in = 1'b1, slow = 1'b0, vreq, vval, exc = 1'b0, exc_ok = 1'b1;
  logic pot_t = 1'b0, conf_t = 1'b0, img_rdy = 1'b0, img_ok = 1'b0, fixed_sec = 1'b0;
  logic hand, fail, dbg, sysr, clr, wdg, crypto, exe, cln, qsec;
  logic [3:0] sp_port, sp_idx;
  logic [1:0] pins = 2'h0, vidx, pst;
  logic [31:0] sp_w = 32'h0, vec = 32'h0, ld_s = 32'h0, ld_e = 32'h0, q_addr = 32'h0;
  logic [31:0] vdata, sp_o, vec_o;
  bss_cause_t cause = '0;
  bss_fuse_t fuse = '0;
  bss_src_t src;
  bss_lc_t lc;
  bss_secpol_t pol;
  bss_tamper_cfg_t tcfg;
  int miscompares = 0, n_checks = 0, clr_cnt = 0, wdg_cnt = 0, cln_cnt = 0;
  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    clr_cnt += int'(clr === 1'b1);
    wdg_cnt += int'(wdg === 1'b1);
    cln_cnt += int'(cln === 1'b1);
  end
  bss_vec_model model (.clk_in(clk_in), .slow_in(slow), .vec_req_in(vreq), .vec_index_in(vidx),
    .sp_word_in(sp_w), .vector_in(vec), .vec_data_out(vdata), .vec_valid_out(vval));
  bss_top dut (.clk_in(clk_in), .reset_in(reset_in), .vec_req_out(vreq), .vec_index_out(vidx),
    .vec_data_in(vdata), .vec_valid_in(vval), .exc_in(exc), .exc_handler_ok_in(exc_ok),
    .hw_reset_cause_reg_in(cause), .cause_clear_out(clr), .system_reset_out(sysr),
    .boot_pins_in(pins), .fuse_in(fuse), .potential_tamper_in(pot_t),
    .confirmed_tamper_in(conf_t), .loader_start_in(ld_s), .loader_end_in(ld_e),
    .image_ready_in(img_rdy), .image_ok_in(img_ok), .query_addr_in(q_addr),
    .fixed_secure_in(fixed_sec), .main_stack_pointer_out(sp_o), .reset_entry_vector_out(vec_o),
    .wdg_reload_out(wdg), .crypto_unblock_out(crypto), .tamper_cfg_out(tcfg),
    .lifecycle_out(lc), .boot_pin_status_out(pst), .sec_pin_port_out(sp_port),
    .sec_pin_index_out(sp_idx),
    .boot_source_out(src), .secpol_out(pol), .data_cache_clean_out(cln), .debug_reopen_out(dbg),
    .handover_out(hand), .fail_out(fail), .query_secure_out(qsec), .query_exec_out(exe));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Resets the block, then waits for handover, failure or debug reopen under a bound
  task automatic boot(input bit want_end, input int limit);
    int i;
    reset_in = 1'b1;
    repeat (10) @(negedge clk_in);
    clr_cnt = 0;
    wdg_cnt = 0;
    cln_cnt = 0;
    reset_in = 1'b0;
    for (i = 0; i < limit && !(hand === 1'b1 || fail === 1'b1 || dbg === 1'b1); i++) begin
      @(negedge clk_in);
    end
    if (want_end && i == limit) begin
      miscompares++;
      $display("[FAIL] terminal state expected 1 seen 0");
      end_of_test();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic dev_boot();
    fuse = '0;
    fuse.lifecycle_unlocked_cfg = 1'b1;
    pins = 2'b10;
    cause = 7'h40;
    sp_w = 32'h24100400;
    vec = 32'h18001001;
    slow = 1'b1;
    boot(1'b1, 400);
    check("debug reopen", 32'h1, dbg);
    check("source", 32'(BSS_SRC_DEV), src);
    check("lifecycle", 32'(BSS_LC_OPEN), lc);
    check("pin status", 32'h2, pst);
    check("stack pointer", sp_w, sp_o);
    check("reset vector", vec, vec_o);
    check("system reset", 32'h1, sysr);
    check("clear pulses", 32'h1, clr_cnt);
    check("attr and instruction_cache", 32'h0, {pol.atu_enable, pol.instruction_cache_enable});
  endtask
  task automatic loader_boot();
    logic [3:0] codes [7] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h8, 4'h0};
    logic [2:0] srcs [7] = '{3'h2, 3'h4, 3'h6, 3'h7, 3'h3, 3'h5, 3'h6};
    fuse.security_control_fuse_word = 32'h00100000;
    fuse.secure_boot_fuse_word = 32'h000001EF;
    slow = 1'b0;
    pot_t = 1'b1;
    {img_rdy, img_ok} = 2'b11;
    ld_s = 32'h34106000; // Aligned image bounds
    ld_e = 32'h34108000;
    for (int k = 0; k < 7; k++) begin
      fuse.flash_boot_select_fuse = {23'h0, codes[k], 5'h00};
      boot(1'b1, 400);
      check("handover", 32'h1, hand);
      check("flash source", 32'(srcs[k]), src);
      check("lifecycle", 32'(BSS_LC_PROV), lc);
      check("attr and instruction_cache", 32'h1, {pol.atu_enable, pol.instruction_cache_enable});
      check("crypto unblock", 32'h0, crypto);
      check("data_cache clean pulses", 32'h1, cln_cnt);
    end
    q_addr = 32'h34106040;
    repeat (2) @(negedge clk_in);
    check("exec inside", 32'h1, exe);
    fuse.flash_boot_select_fuse = 32'h00000080;
    boot(1'b1, 400);
    check("unlisted code fail", 32'h1, fail);
  endtask
  task automatic fail_boot();
    fuse.secure_boot_fuse_word = 32'h0000000F;
    fuse.flash_boot_select_fuse = 32'h00000020;
    ld_s = 32'h34106004;
    fuse.boot_pin_remap_fuse = 32'h12600000;
    boot(1'b1, 400);
    check("lifecycle", 32'(BSS_LC_UNPROV), lc);
    check("misaligned fail", 32'h1, fail);
    check("fail policy", {25'h0, 7'h7F}, 32'(pol.fw_secure_only));
    check("fail keep and caches", 32'hC, {pol.atu_enable, pol.mpu_keep, pol.instruction_cache_enable,
      pol.data_cache_enable});
    check("crypto unblock", 32'h0, crypto);
    check("pin remap", 32'h39, {sp_port, sp_idx});
    q_addr = 32'h20000000;
    @(negedge clk_in);
    check("attr nonsecure", 32'h0, qsec);
    fixed_sec = 1'b1;
    @(negedge clk_in);
    check("fixed secure wins", 32'h1, qsec);
    {exc, exc_ok} = 2'b10;
    boot(1'b1, 400);
    check("exception fail", 32'h1, fail);
    check("no stack fetch", 32'h0, sp_o);
    {exc, exc_ok} = 2'b01;
  endtask
  task automatic tamper_boot();
    fuse = '0;
    fuse.lifecycle_unlocked_cfg = 1'b1;
    fuse.security_control_fuse_word = 32'h00000001;
    fuse.boot_tamper_enable_fuse_word = 32'h00000002;
    fuse.tamper_enable_fuse_word = 32'h0007FFFF;
    fuse.tamper_level_fuse_word = 32'h000000A5;
    pins = 2'b00;
    cause = 7'h41;
    conf_t = 1'b1;
    boot(1'b0, 700);
    check("no progress", 32'h0, {hand, fail});
    check("tamper enable", 32'h0005FFFF, 32'(tcfg.enable));
    check("tamper level", 32'h000000A5, 32'(tcfg.active_high));
    check("two causes", 32'h0, sysr);
    check("reload pulses", 32'h1, 32'(wdg_cnt >= 2));
  endtask
  initial begin
    dev_boot();
    loader_boot();
    fail_boot();
    tamper_boot();
    end_of_test();
  end
endmodule
`default_nettype wire
